// File: timer_pkg.sv
package timer_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W         = 3;
  localparam logic [2:0]  REG_RUN_PERIOD = 3'h0;
  localparam logic [2:0]  REG_MODE_OUT   = 3'h1;
  localparam logic [2:0]  REG_COUNT_LOW  = 3'h2;
  localparam logic [2:0]  REG_COUNT_HIGH = 3'h3;
  localparam logic [2:0]  REG_CMPA_LOW   = 3'h4;
  localparam logic [2:0]  REG_CMPA_HIGH  = 3'h5;
  localparam logic [7:0]  RST_RUN_PERIOD = 8'h00;
  localparam logic [7:0]  RST_MODE_OUT   = 8'h00;
  localparam logic [9:0]  RST_COUNT      = 10'h000;
  localparam logic [9:0]  RST_CMPA       = 10'h000;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned PERIOD_LSB     = 0;
  localparam int unsigned RUN_POS        = 3;
  localparam int unsigned CLKSEL_LSB     = 4;
  localparam int unsigned MODE_LSB       = 6;
  localparam int unsigned ACTION_LSB     = 4;
  localparam int unsigned INIT_POS       = 3;
  localparam int unsigned INVERT_POS     = 2;
  localparam int unsigned SWAP_POS       = 1;
  localparam int unsigned CLRSEL_POS     = 0;

  // ---------------------------------------------------------------------------
  // Counting constants
  // ---------------------------------------------------------------------------
  localparam logic [10:0] FULL_COUNT     = 11'h400;
  localparam logic [10:0] ONE_COUNT      = 11'h001;
  localparam logic [5:0]  DIV1_LAST      = 6'h00;
  localparam logic [5:0]  DIV4_LAST      = 6'h03;
  localparam logic [5:0]  DIV16_LAST     = 6'h0F;
  localparam logic [5:0]  DIV64_LAST     = 6'h3F;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_UNDEF   = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } op_mode_e;

  typedef enum logic [1:0] {
    ACT_HOLD   = 2'b00,
    ACT_LOW    = 2'b01,
    ACT_HIGH   = 2'b10,
    ACT_TOGGLE = 2'b11
  } cmp_action_e;

  typedef enum logic [1:0] {
    PWM_INACTIVE = 2'b00,
    PWM_ACTIVE   = 2'b01,
    PWM_WAVE     = 2'b10,
    PWM_UNDEF    = 2'b11
  } pwm_action_e;

endpackage

// File: tick_divider.sv
`timescale 1ns/1ps
module tick_divider
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       enable,
  input  wire logic [1:0] sel,
  output logic            tick
);
  import timer_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
  } div_state_s;

  div_state_s st_q;
  div_state_s st_d;
  logic [5:0] last;

  // ---------------------------------------------------------------------------
  // Divide select
  // ---------------------------------------------------------------------------
  always_comb
  begin
    unique case (sel)
      2'b00:   last = DIV1_LAST;
      2'b01:   last = DIV4_LAST;
      2'b10:   last = DIV16_LAST;
      2'b11:   last = DIV64_LAST;
    endcase
  end

  assign tick = enable && (st_q.cnt >= last);

  // ---------------------------------------------------------------------------
  // Divider counter
  // ---------------------------------------------------------------------------
  // Held at zero while stopped so that every start gives a full first period.
  always_comb
  begin
    st_d = st_q;
    if (!enable || tick)
    begin
      st_d.cnt = 6'h00;
    end
    else
    begin
      st_d.cnt = st_q.cnt + 6'h01;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

endmodule

// File: compact_timer_control.sv
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module compact_timer_control
(
  input  wire logic                        CLOCK,
  input  wire logic                        RST_B,
  input  wire logic [timer_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [7:0]                  WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [7:0]                  RDATA,
  output logic                             TIMER_OUTPUT_PIN,
  output logic                             TIMER_OUTPUT_EN,
  output logic                             MATCH_A_FLAG,
  output logic                             PERIOD_MATCH_FLAG
);
  import timer_pkg::*;

  typedef struct packed {
    logic [7:0] run_period;
    logic [7:0] mode_out;
    logic [9:0] count;
    logic [9:0] cmp_a;
    logic       run_prev;
    logic       level;
    logic [7:0] rdata;
    logic       pin;
    logic       pin_en;
    logic       flag_a;
    logic       flag_p;
  } timer_state_s;

  timer_state_s st_q;
  timer_state_s st_d;

  logic         run_bit;
  logic         run_rise;
  logic         tick;
  logic [2:0]   period_setting;
  op_mode_e     op_mode;
  logic [1:0]   output_action;
  logic         output_init_level;
  logic         output_invert;
  logic         period_duty_swap;
  logic         clear_select;
  logic         pwm_mode;
  logic         clear_on_a;
  logic [10:0]  cmp_a_ext;
  logic [10:0]  period_p;
  logic [10:0]  period_len;
  logic [10:0]  duty_len;
  logic [10:0]  next_cnt;
  logic         match_a;
  logic         match_p;
  logic         pwm_active;
  logic         pwm_level;

  // ---------------------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------------------
  assign run_bit           = st_q.run_period[RUN_POS];
  assign run_rise          = run_bit && !st_q.run_prev;
  assign period_setting    = st_q.run_period[PERIOD_LSB +: 3];
  assign op_mode           = op_mode_e'(st_q.mode_out[MODE_LSB +: 2]);
  assign output_action     = st_q.mode_out[ACTION_LSB +: 2];
  assign output_init_level = st_q.mode_out[INIT_POS];
  assign output_invert     = st_q.mode_out[INVERT_POS];
  assign period_duty_swap  = st_q.mode_out[SWAP_POS];
  assign clear_select      = st_q.mode_out[CLRSEL_POS];
  assign pwm_mode          = (op_mode == MODE_PWM);

  // The tick is held off in the run-rise cycle so that the cleared counter
  // is not advanced in the same cycle.
  tick_divider u_tick_divider
  (
    .clock  (CLOCK),
    .rst_b  (RST_B),
    .enable (run_bit && !run_rise),
    .sel    (st_q.run_period[CLKSEL_LSB +: 2]),
    .tick   (tick)
  );

  // ---------------------------------------------------------------------------
  // Comparators
  // ---------------------------------------------------------------------------
  // Period setting k lands on counter value 128*k; zero stands for the wrap.
  assign period_p   = (period_setting == 3'b000) ? FULL_COUNT : {1'b0, period_setting, 7'h00};
  assign cmp_a_ext  = {1'b0, st_q.cmp_a};
  assign clear_on_a = pwm_mode ? period_duty_swap : clear_select;
  // A compare A value of zero cannot be reached, so the counter wraps instead.
  assign period_len = clear_on_a ? ((st_q.cmp_a == 10'h000) ? FULL_COUNT : cmp_a_ext)
                                 : period_p;
  assign duty_len   = (pwm_mode && period_duty_swap) ? period_p : cmp_a_ext;
  assign next_cnt   = {1'b0, st_q.count} + ONE_COUNT;
  assign match_a    = (st_q.cmp_a != 10'h000) && (next_cnt == cmp_a_ext);
  // Clearing on match A suppresses the period flag outside pulse-width mode.
  assign match_p    = (next_cnt == period_p) && !(clear_on_a && !pwm_mode);

  // ---------------------------------------------------------------------------
  // Pulse-width waveform
  // ---------------------------------------------------------------------------
  // The count is named directly so that every counter step re-evaluates the level.
  assign pwm_active = run_bit && ((duty_len >= period_len) || ({1'b0, st_q.count} < duty_len));

  always_comb
  begin
    unique case (pwm_action_e'(output_action))
      PWM_INACTIVE: pwm_level = !output_init_level;
      PWM_ACTIVE:   pwm_level = output_init_level;
      PWM_WAVE:     pwm_level = pwm_active ? output_init_level : !output_init_level;
      PWM_UNDEF:    pwm_level = !output_init_level;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    st_d          = st_q;
    st_d.run_prev = run_bit;
    st_d.flag_a   = 1'b0;
    st_d.flag_p   = 1'b0;
    st_d.rdata    = 8'h00;

    // Register writes; counter registers are read-only and ignore writes.
    if (WR)
    begin
      unique case (ADDR)
        REG_RUN_PERIOD: st_d.run_period = WDATA;
        REG_MODE_OUT:   st_d.mode_out = WDATA;
        REG_CMPA_LOW:   st_d.cmp_a[7:0] = WDATA;
        REG_CMPA_HIGH:  st_d.cmp_a[9:8] = WDATA[1:0];
        default:        st_d.cmp_a = st_q.cmp_a;
      endcase
    end

    // Register reads; data appear in the following cycle only.
    if (RD)
    begin
      unique case (ADDR)
        REG_RUN_PERIOD: st_d.rdata = st_q.run_period;
        REG_MODE_OUT:   st_d.rdata = st_q.mode_out;
        REG_COUNT_LOW:  st_d.rdata = st_q.count[7:0];
        REG_COUNT_HIGH: st_d.rdata = {6'h00, st_q.count[9:8]};
        REG_CMPA_LOW:   st_d.rdata = st_q.cmp_a[7:0];
        REG_CMPA_HIGH:  st_d.rdata = {6'h00, st_q.cmp_a[9:8]};
        default:        st_d.rdata = 8'h00;
      endcase
    end

    // Counting; a stopped timer keeps its residual count.
    if (run_rise)
    begin
      st_d.count = RST_COUNT;
      if (op_mode == MODE_COMPARE)
      begin
        st_d.level = output_init_level;
      end
    end
    else if (tick)
    begin
      st_d.count  = (next_cnt == period_len) ? RST_COUNT : next_cnt[9:0];
      st_d.flag_a = match_a;
      st_d.flag_p = match_p;
      // Besides a start, only match A moves the level; a request equal to it shows no change.
      if (match_a && op_mode == MODE_COMPARE)
      begin
        unique case (cmp_action_e'(output_action))
          ACT_HOLD:   st_d.level = st_q.level;
          ACT_LOW:    st_d.level = 1'b0;
          ACT_HIGH:   st_d.level = 1'b1;
          ACT_TOGGLE: st_d.level = !st_q.level;
        endcase
      end
    end

    // Pin drive; timer and undefined modes release the pin.
    unique case (op_mode)
      MODE_COMPARE:
      begin
        st_d.pin    = st_q.level ^ output_invert;
        st_d.pin_en = 1'b1;
      end
      MODE_PWM:
      begin
        st_d.pin    = pwm_level ^ output_invert;
        st_d.pin_en = 1'b1;
      end
      MODE_TIMER, MODE_UNDEF:
      begin
        st_d.pin    = 1'b0;
        st_d.pin_en = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (!RST_B)
    begin
      st_q            <= '0;
      st_q.run_period <= RST_RUN_PERIOD;
      st_q.mode_out   <= RST_MODE_OUT;
      st_q.count      <= RST_COUNT;
      st_q.cmp_a      <= RST_CMPA;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign RDATA             = st_q.rdata;
  assign TIMER_OUTPUT_PIN  = st_q.pin;
  assign TIMER_OUTPUT_EN   = st_q.pin_en;
  assign MATCH_A_FLAG      = st_q.flag_a;
  assign PERIOD_MATCH_FLAG = st_q.flag_p;

endmodule

// File: timer_checker.sv
`timescale 1ns/1ps
module timer_checker
(
  input wire logic                          CLOCK,
  input wire logic                          RST_B,
  input wire logic [timer_pkg::ADDR_W-1:0]  ADDR,
  input wire logic [7:0]                    WDATA,
  input wire logic                          WR,
  input wire logic                          RD,
  input wire logic [7:0]                    RDATA,
  input wire logic                          TIMER_OUTPUT_PIN,
  input wire logic                          TIMER_OUTPUT_EN,
  input wire logic                          MATCH_A_FLAG,
  input wire logic                          PERIOD_MATCH_FLAG
);
  import timer_pkg::*;
  // Pin checks wait a few quiet cycles after any write, since a register change takes
  // up to three cycles to reach the pin and would otherwise look like a spurious edge.
  logic [7:0] ctrl_q;
  logic [2:0] quiet_q;
  always_ff @(posedge CLOCK)
  begin
    if (!RST_B)
    begin
      ctrl_q  <= 8'h00;
      quiet_q <= 3'h0;
    end
    else
    begin
      if (WR && ADDR == REG_MODE_OUT)
        ctrl_q <= WDATA;
      if (WR)
        quiet_q <= 3'h0;
      else if (quiet_q != 3'h7)
        quiet_q <= quiet_q + 3'h1;
    end
  end
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);
  a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data not idle");
  a_high_zero: assert property (RD && (ADDR == REG_COUNT_HIGH || ADDR == REG_CMPA_HIGH) |=> RDATA[7:2] == 6'h00)
    else $error("high byte upper bits set");
  a_match_pulse: assert property (MATCH_A_FLAG |=> !MATCH_A_FLAG)
    else $error("match flag too long");
  a_period_pulse: assert property (PERIOD_MATCH_FLAG |=> !PERIOD_MATCH_FLAG)
    else $error("period flag too long");
  a_timer_released: assert property (quiet_q >= 3'h3 && ctrl_q[7:6] == MODE_TIMER |-> !TIMER_OUTPUT_EN)
    else $error("pin driven in timer mode");
  a_compare_driven: assert property (quiet_q >= 3'h3 && ctrl_q[7:6] == MODE_COMPARE |-> TIMER_OUTPUT_EN)
    else $error("pin not driven in compare mode");
  a_hold_steady: assert property (quiet_q >= 3'h5 && ctrl_q[7:4] == 4'h0 |-> $stable(TIMER_OUTPUT_PIN))
    else $error("pin moved with hold action");
  a_pin_cause: assert property (quiet_q >= 3'h5 && ctrl_q[7:6] == MODE_COMPARE && $changed(TIMER_OUTPUT_PIN)
    |-> $past(MATCH_A_FLAG) || $past(MATCH_A_FLAG, 2))
    else $error("pin moved without match");
endmodule
bind compact_timer_control timer_checker chk_i
(
  .CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN), .TIMER_OUTPUT_EN(TIMER_OUTPUT_EN),
  .MATCH_A_FLAG(MATCH_A_FLAG), .PERIOD_MATCH_FLAG(PERIOD_MATCH_FLAG)
);

// File: tb.sv
`timescale 1ns/1ps
module tb;
  import timer_pkg::*;
  logic              clock = 1'b0;
  logic              rst_b = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0]        wdata = 8'h00;
  logic              wr_stb = 1'b0;
  logic              rd_stb = 1'b0;
  logic [7:0]        rdata;
  logic              pin;
  logic              pin_en;
  logic              flag_a;
  logic              flag_p;
  logic [7:0]        rv;
  int                num_errors = 0;
  int                checks_done = 0;
  int                n;
  int                i;
  int                ca [6] = '{32, 200, 256, 32, 32, 32};
  logic [7:0]        ctl [6] = '{8'hA9, 8'hA9, 8'hAB, 8'h89, 8'h99, 8'hAD};
  int                wl [6] = '{128, 128, 256, 128, 128, 128};
  int                hx [6] = '{32, 128, 128, 0, 128, 96};

  always #20 clock = ~clock;

  compact_timer_control uut
  (
    .CLOCK(clock), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr_stb), .RD(rd_stb),
    .RDATA(rdata), .TIMER_OUTPUT_PIN(pin), .TIMER_OUTPUT_EN(pin_en),
    .MATCH_A_FLAG(flag_a), .PERIOD_MATCH_FLAG(flag_p)
  );

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask

  // Returns the cycles waited, so two calls in a row measure one full period.
  task automatic wait_flag(input bit p, output int c);
    for (c = 1; c <= 2100; c++)
    begin
      settle(1);
      if ((p ? flag_p : flag_a) === 1'b1)
        break;
    end
    if (c > 2100)
      chk("flag wait", 11'h001, 11'h000);
  endtask

  initial
  begin
    repeat (40000) @(posedge clock);
    chk("watchdog", 11'h001, 11'h000);
    end_sim();
  end

  initial
  begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      rd(i[2:0], rv);
      chk("reset read", 11'h000, 11'(rv));
    end
    wr(REG_CMPA_LOW, 8'hA5);
    wr(REG_CMPA_HIGH, 8'hFF);
    wr(REG_COUNT_LOW, 8'h5A);
    rd(REG_CMPA_LOW, rv);
    chk("cmpa low", 11'h0A5, 11'(rv));
    rd(REG_CMPA_HIGH, rv);
    chk("cmpa high", 11'h003, 11'(rv));
    rd(REG_COUNT_LOW, rv);
    chk("count low", 11'h000, 11'(rv));
    wr(REG_MODE_OUT, 8'hC0);
    for (i = 0; i < 3; i++)
    begin
      wr(REG_RUN_PERIOD, 8'h08 | 8'(i * 3));
      wait_flag(1'b1, n);
      wait_flag(1'b1, n);
      chk("period", 11'(i != 0 ? 384 * i : 1024), 11'(n));
    end
    chk("timer enable", 11'h000, 11'(pin_en));
    wait_flag(1'b1, n);
    settle(300);
    wr(REG_RUN_PERIOD, 8'h06);
    settle(50);
    rd(REG_COUNT_HIGH, rv);
    chk("stop high", 11'h001, 11'(rv));
    rd(REG_COUNT_LOW, rv);
    chk("stop low", 11'h001, 11'(rv > 8'h28 && rv < 8'h34));
    wr(REG_RUN_PERIOD, 8'h0E);
    rd(REG_COUNT_LOW, rv);
    chk("restart", 11'h001, 11'(rv < 8'h04));
    wr(REG_RUN_PERIOD, 8'h01);
    wr(REG_CMPA_HIGH, 8'h00);
    wr(REG_CMPA_LOW, 8'h64);
    wr(REG_MODE_OUT, 8'h01);
    wr(REG_RUN_PERIOD, 8'h09);
    wait_flag(1'b0, n);
    wait_flag(1'b0, n);
    chk("clear on a", 11'h064, 11'(n));
    for (i = 1; i < 3; i++)
    begin
      wr(REG_RUN_PERIOD, 8'h09 | 8'(i << 4));
      wait_flag(1'b0, n);
      wait_flag(1'b0, n);
      chk("divided period", 11'(100 << (2 * i)), 11'(n));
    end
    for (i = 0; i < 16; i++)
    begin
      wr(REG_RUN_PERIOD, 8'h01);
      wr(REG_MODE_OUT, {2'b00, i[1:0], i[2], i[3], 2'b00});
      wr(REG_RUN_PERIOD, 8'h09);
      settle(4);
      chk("init level", 11'(i[2] ^ i[3]), 11'(pin));
      wait_flag(1'b0, n);
      settle(2);
      chk("match level", 11'((i[1:0] == 2'b00 ? i[2] : i[1:0] == 2'b11 ? !i[2] : i[1]) ^ i[3]), 11'(pin));
      chk("cmp enable", 11'h001, 11'(pin_en));
    end
    for (i = 0; i < 6; i++)
    begin
      wr(REG_RUN_PERIOD, 8'h01);
      wr(REG_CMPA_HIGH, 8'(ca[i] >> 8));
      wr(REG_CMPA_LOW, 8'(ca[i]));
      wr(REG_MODE_OUT, ctl[i]);
      wr(REG_RUN_PERIOD, 8'h09);
      settle(600);
      n = 0;
      repeat (wl[i])
      begin
        settle(1);
        n += int'(pin === 1'b1);
      end
      chk("pwm high", 11'(hx[i]), 11'(n));
    end
    end_sim();
  end
endmodule
